// File: hdl/pbm_pkg.sv
package pbm_pkg;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NBINS = 7;
  localparam int unsigned NLIMITS = 6;
  localparam int unsigned SAMPLE_W = 9;
  localparam int unsigned RESULT_W = 24;
  localparam int unsigned COEF_W = 16;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned BIN_FIELD_W = 4;
  localparam int unsigned ALPHA_POS = 3;
  localparam int unsigned ALPHA_SHIFT = 8;
  localparam int unsigned MAP_W = 28;
  localparam int unsigned KP1_POS = 16;

  // byte addresses of the register window
  localparam logic [19:0] OFF_KD_RESULT = 20'hc0014;
  localparam logic [19:0] OFF_OUT_RESULT = 20'hc0018;
  localparam logic [19:0] OFF_BIN_MAP = 20'hc001c;
  localparam logic [19:0] OFF_KP_PAIR = 20'hc0020;

  // values after reset, and the selector codes of sets A and B
  localparam logic [27:0] RST_BIN_MAP = 28'h0000000;
  localparam logic [15:0] RST_KP_ZERO = 16'h4234;
  localparam logic [15:0] RST_KP_ONE = 16'h0000;
  localparam logic [2:0] SET_A = 3'h0;
  localparam logic [2:0] SET_B = 3'h1;

  typedef struct packed {
    logic valid;
    logic signed [8:0] err;
  } pbm_sample_t;

  typedef struct packed {
    logic [2:0] bin;
    logic [2:0] set_sel;
    logic alpha_sel;
  } pbm_select_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SELECT,
    ST_CALC
  } pbm_state_t;
endpackage

// File: hdl/pbm_filter_map.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// (RULE1) derivative result and filter output are 24-bit signed read-only registers.
// (RULE2) each of bins 0..6 has a 3-bit selector mapping it to coefficient sets A..G.
// (RULE3) each bin has an alpha bit choosing derivative alpha bank 0 or bank 1.
// (RULE4) map writes land in a shadow and reach the filter only while no sample is processed.
// (RULE5) after reset every bin selects set A and alpha bank 0, so the map reads zero.
// (RULE6) proportional coefficients 0 and 1 share one word, low half resets to 0x4234.
// (RULE7) any proportional coefficient can serve any bin through the set selectors.
// (RULE8) the bin is chosen by comparing the error with limits zero to five.
// (RULE9) the gain table is non-symmetric by default and symmetric when the mode bit is 1.
// (RULE10) selector value 7 is reserved and its behaviour is left undefined.
module pbm_filter_map (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [19:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire pbm_pkg::pbm_sample_t i_sample,
  input wire logic [5:0][8:0] i_limits,
  input wire logic i_gain_table_symmetry,
  input wire logic [6:0][15:0] i_kp_sets,
  input wire logic [6:0][15:0] i_kd_sets,
  input wire logic [8:0] i_alpha_bank_zero,
  input wire logic [8:0] i_alpha_bank_one,
  output logic o_busy,
  output pbm_pkg::pbm_select_t o_select,
  output logic o_result_valid
);
  localparam int unsigned SUM_W = 28;

  pbm_pkg::pbm_state_t state_q, state_d;
  logic [27:0] shadow_q, shadow_d, active_q, active_d;
  logic [15:0] kp0_q, kp0_d, kp1_q, kp1_d;
  logic [23:0] kd_res_q, kd_res_d, out_q, out_d;
  logic [31:0] rdata_q, rdata_d;
  logic signed [8:0] x_q, x_d, xprev_q, xprev_d;
  pbm_pkg::pbm_select_t sel_q, sel_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  logic [2:0] bin_c;
  logic [2:0] above_c;
  logic signed [8:0] mag_c;
  logic signed [15:0] kp_c, kd_c;
  logic signed [8:0] alpha_c;
  logic signed [SUM_W-1:0] kd_sum_c, out_sum_c;

  // clamp a wide signed sum into the 24-bit result range
  function automatic logic [23:0] sat24(input logic signed [SUM_W-1:0] v);
    logic signed [SUM_W-1:0] hi;
    logic signed [SUM_W-1:0] lo;
    hi = SUM_W'(signed'(24'h7fffff));
    lo = SUM_W'(signed'(24'h800000));
    if (v > hi) begin
      sat24 = 24'h7fffff;
    end else if (v < lo) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  // bin search: limits are taken as signed thresholds in rising order
  always_comb begin
    bin_c = 3'h0;
    above_c = 3'h0;
    mag_c = x_q[8] ? -x_q : x_q;
    if (i_gain_table_symmetry) begin // see (RULE9)
      // mirrored table: the magnitude climbs limits 0..2 away from centre bin 3
      for (int i = 0; i < 3; i++) begin
        if (mag_c > $signed(i_limits[i])) begin
          above_c = above_c + 3'h1;
        end
      end
      bin_c = x_q[8] ? 3'h3 - above_c : 3'h3 + above_c;
    end else begin
      for (int i = 0; i < 6; i++) begin // see (RULE8)
        if (x_q > $signed(i_limits[i])) begin
          bin_c = bin_c + 3'h1;
        end
      end
    end
  end

  // coefficient pick: proportional sets A and B come from the local pair, the other proportional sets and every derivative set from outside
  always_comb begin
    case (sel_q.set_sel) // see (RULE7)
      pbm_pkg::SET_A: kp_c = kp0_q;
      pbm_pkg::SET_B: kp_c = kp1_q;
      default: kp_c = i_kp_sets[sel_q.set_sel]; // value 7 indexes past the table, see (RULE10)
    endcase
    kd_c = i_kd_sets[sel_q.set_sel];
    alpha_c = sel_q.alpha_sel ? i_alpha_bank_one : i_alpha_bank_zero; // see (RULE3)
    kd_sum_c = SUM_W'(kd_c * (10'(x_q) - 10'(xprev_q)))
      + SUM_W'((36'(alpha_c) * 36'($signed(kd_res_q))) >>> pbm_pkg::ALPHA_SHIFT);
    // alpha product is formed at full width so it cannot wrap before the shift
    out_sum_c = SUM_W'(kp_c * x_q) + SUM_W'($signed(sat24(kd_sum_c)));
  end

  // sequencer and register bus next values
  always_comb begin
    state_d = state_q;
    shadow_d = shadow_q;
    active_d = active_q;
    kp0_d = kp0_q;
    kp1_d = kp1_q;
    kd_res_d = kd_res_q;
    out_d = out_q;
    x_d = x_q;
    xprev_d = xprev_q;
    sel_d = sel_q;
    done_d = 1'b0;
    rdata_d = 32'h00000000;
    case (state_q)
      pbm_pkg::ST_IDLE: begin
        if (i_sample.valid) begin
          x_d = i_sample.err;
          state_d = pbm_pkg::ST_SELECT;
        end
      end
      pbm_pkg::ST_SELECT: begin
        // bin lookup uses the active map only, never the shadow
        sel_d.bin = bin_c;
        sel_d.set_sel = active_q[bin_c * 4 +: 3]; // see (RULE2)
        sel_d.alpha_sel = active_q[bin_c * 4 + 3];
        state_d = pbm_pkg::ST_CALC;
      end
      pbm_pkg::ST_CALC: begin
        kd_res_d = sat24(kd_sum_c); // see (RULE1)
        out_d = sat24(out_sum_c);
        xprev_d = x_q;
        done_d = 1'b1;
        state_d = pbm_pkg::ST_IDLE;
      end
      default: state_d = pbm_pkg::ST_IDLE;
    endcase
    // busy is registered from the next state so the pin is a clean flop output
    busy_d = (state_d != pbm_pkg::ST_IDLE);
    // a sample arriving this cycle blocks the copy so it cannot see a half-changed map
    if (state_q == pbm_pkg::ST_IDLE && !i_sample.valid) begin
      active_d = shadow_q; // see (RULE4)
    end
    if (i_wr) begin
      case (i_addr)
        pbm_pkg::OFF_BIN_MAP: shadow_d = i_wdata[27:0]; // see (RULE4)
        pbm_pkg::OFF_KP_PAIR: begin
          kp0_d = i_wdata[15:0]; // see (RULE6)
          kp1_d = i_wdata[31:16];
        end
        default: ; // result registers ignore writes
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        pbm_pkg::OFF_KD_RESULT: rdata_d = {8'h00, kd_res_q}; // see (RULE1)
        pbm_pkg::OFF_OUT_RESULT: rdata_d = {8'h00, out_q};
        pbm_pkg::OFF_BIN_MAP: rdata_d = {4'h0, shadow_q};
        pbm_pkg::OFF_KP_PAIR: rdata_d = {kp1_q, kp0_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= pbm_pkg::ST_IDLE;
      shadow_q <= pbm_pkg::RST_BIN_MAP; // see (RULE5)
      active_q <= pbm_pkg::RST_BIN_MAP;
      kp0_q <= pbm_pkg::RST_KP_ZERO; // see (RULE6)
      kp1_q <= pbm_pkg::RST_KP_ONE;
      kd_res_q <= 24'h000000;
      out_q <= 24'h000000;
      busy_q <= 1'b0;
      x_q <= 9'h000;
      xprev_q <= 9'h000;
      sel_q <= '0;
      done_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      shadow_q <= shadow_d;
      active_q <= active_d;
      kp0_q <= kp0_d;
      kp1_q <= kp1_d;
      kd_res_q <= kd_res_d;
      out_q <= out_d;
      busy_q <= busy_d;
      x_q <= x_d;
      xprev_q <= xprev_d;
      sel_q <= sel_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
    end
  end

  // every output is driven straight from its flop
  assign o_busy = busy_q;
  assign o_select = sel_q;
  assign o_result_valid = done_q;
  assign o_rdata = rdata_q;

  a_map_no_change_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see (RULE4)
    state_q != pbm_pkg::ST_IDLE |=> $stable(active_q))
    else $error("active map changed during a calculation");
  a_map_copy_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see (RULE4)
    state_q == pbm_pkg::ST_IDLE && !i_sample.valid |=> active_q == $past(shadow_q))
    else $error("shadow not copied while idle");
  a_set_from_map: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see (RULE2)
    state_q == pbm_pkg::ST_SELECT |=> sel_q.set_sel == $past(active_q[bin_c * 4 +: 3]))
    else $error("set selector not taken from the bin field");
  a_alpha_from_map: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see (RULE3)
    state_q == pbm_pkg::ST_SELECT |=> sel_q.alpha_sel == $past(active_q[bin_c * 4 + 3]))
    else $error("alpha bit not taken from the bin field");
  a_reset_values: assert property (@(posedge i_clk) // see (RULE5)
    $past(i_sys_rst) |-> shadow_q == 28'h0000000 && kp0_q == 16'h4234 && kp1_q == 16'h0000)
    else $error("wrong value after reset");
  a_kp_read_back: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see (RULE6)
    i_wr && i_addr == pbm_pkg::OFF_KP_PAIR ##1 i_rd && i_addr == pbm_pkg::OFF_KP_PAIR
    |=> o_rdata == $past(i_wdata, 2))
    else $error("coefficient pair read back wrong");
  a_result_ro: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see (RULE1)
    i_wr && i_addr == pbm_pkg::OFF_OUT_RESULT && state_q != pbm_pkg::ST_CALC |=> $stable(out_q))
    else $error("write changed the output result");
  a_read_upper_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see (RULE1)
    i_rd && i_addr == pbm_pkg::OFF_KD_RESULT |=> o_rdata[31:24] == 8'h00)
    else $error("result read has upper bits set");
  a_sample_latency: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see (RULE8)
    state_q == pbm_pkg::ST_IDLE && i_sample.valid |-> ##3 o_result_valid)
    else $error("result not ready three cycles after a sample");
  a_sym_centre: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see (RULE9)
    state_q == pbm_pkg::ST_SELECT && i_gain_table_symmetry && x_q == 9'h000 |=> sel_q.bin == 3'h3)
    else $error("symmetric table not centred on bin 3");
endmodule
`default_nettype wire

// File: sim/pbm_filter_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pbm_filter_map_tb;
  logic i_clk, i_sys_rst, i_wr, i_rd, i_gain_table_symmetry, o_busy, o_result_valid;
  logic rd_pend, vld_pend;
  logic [19:0] i_addr;
  logic [31:0] i_wdata, o_rdata, map, nm;
  pbm_pkg::pbm_sample_t i_sample;
  logic [5:0][8:0] i_limits;
  logic [6:0][15:0] i_kp_sets, i_kd_sets;
  logic [8:0] i_alpha_bank_zero, i_alpha_bank_one;
  pbm_pkg::pbm_select_t o_select;
  logic [31:0] rq[$];
  pbm_pkg::pbm_select_t sq[$];
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 32'h3c370811;
  // errors chosen so both limit layouts put them in bins 0..6
  int errs[7] = '{-250, -150, -50, 0, 50, 150, 250};
  int lns[6] = '{-200, -100, -20, 20, 100, 200};
  int lsym[6] = '{20, 100, 200, 0, 0, 0};

  pbm_filter_map pbm_filter_map_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sample(i_sample),
    .i_limits(i_limits), .i_gain_table_symmetry(i_gain_table_symmetry),
    .i_kp_sets(i_kp_sets), .i_kd_sets(i_kd_sets), .i_alpha_bank_zero(i_alpha_bank_zero),
    .i_alpha_bank_one(i_alpha_bank_one), .o_busy(o_busy), .o_select(o_select),
    .o_result_valid(o_result_valid));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp32(input string nm_s, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm_s, exp, got);
    end
  endtask

  task automatic cmp_sel(input pbm_pkg::pbm_select_t exp, input pbm_pkg::pbm_select_t got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH select expected %h seen %h", exp, got);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    rq.push_back(exp);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask

  function automatic pbm_pkg::pbm_select_t exp_sel(input logic [31:0] m, input int b);
    return '{3'(b), m[4*b +: 3], m[4*b+3]};
  endfunction

  // drop asks for a second valid while busy, which must leave no trace
  task automatic smp(input int b, input logic drop);
    @(posedge i_clk);
    i_sample <= '{1'b1, 9'(errs[b])};
    sq.push_back(exp_sel(map, b));
    @(posedge i_clk);
    i_sample.valid <= drop;
    @(posedge i_clk);
    i_sample.valid <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask

  // watcher: read data only in the cycle after the strobe, select at result pulse
  always @(posedge i_clk) begin
    rd_pend <= i_rd;
    vld_pend <= i_sample.valid;
    if (rd_pend === 1'b1) cmp32("rdata", rq.pop_front(), o_rdata);
    // any valid, taken or dropped, finds the block busy one edge later
    if (vld_pend === 1'b1) cmp32("busy", 32'h1, 32'(o_busy));
    if (o_result_valid === 1'b1) begin
      cmp32("busy at result", 32'h0, 32'(o_busy));
      if (sq.size() > 0) cmp_sel(sq.pop_front(), o_select);
      else cmp32("extra result", 32'h0, 32'h1);
    end
  end

  // hang guard, far above the roughly 130 cycles the sequence needs
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    i_sys_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 20'h00000;
    i_wdata = 32'h0;
    i_sample = '0;
    i_limits = '0;
    i_gain_table_symmetry = 1'b0;
    for (int k = 0; k < 7; k++) i_kp_sets[k] = 16'($random(seed));
    for (int k = 0; k < 7; k++) i_kd_sets[k] = 16'($random(seed));
    i_alpha_bank_zero = 9'($random(seed));
    i_alpha_bank_one = 9'($random(seed));
    map = 32'h0;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(pbm_pkg::OFF_BIN_MAP, 32'h0);
    rd(pbm_pkg::OFF_KP_PAIR, {pbm_pkg::RST_KP_ONE, pbm_pkg::RST_KP_ZERO});
    // read-only results and an unmapped word ignore writes
    wr(pbm_pkg::OFF_KD_RESULT, $random(seed));
    wr(pbm_pkg::OFF_OUT_RESULT, $random(seed));
    wr(20'hc0024, $random(seed));
    rd(pbm_pkg::OFF_KD_RESULT, 32'h0);
    rd(pbm_pkg::OFF_OUT_RESULT, 32'h0);
    rd(20'hc0024, 32'h0);
    nm = $random(seed);
    // write then read with no gap, as the bus allows
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= pbm_pkg::OFF_KP_PAIR;
    i_wdata <= nm;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    rq.push_back(nm);
    @(posedge i_clk);
    i_rd <= 1'b0;
    // both table layouts, random legal map, every bin hit
    for (int m = 0; m < 2; m++) begin
      i_gain_table_symmetry <= m[0];
      for (int k = 0; k < 6; k++) i_limits[k] <= 9'(m ? lsym[k] : lns[k]);
      map = 32'h0;
      for (int b = 0; b < 7; b++) map[4*b +: 4] = {1'($random(seed)), 3'($unsigned($random(seed)) % 7)};
      wr(pbm_pkg::OFF_BIN_MAP, map);
      rd(pbm_pkg::OFF_BIN_MAP, map);
      for (int b = 0; b < 7; b++) smp(b, b == 2);
    end
    // map write beside a taken sample: that sample keeps the old selection
    nm = map;
    nm[22:20] = (map[22:20] == 3'h6) ? 3'h0 : map[22:20] + 3'h1;
    nm[23] = ~map[23];
    @(posedge i_clk);
    i_sample <= '{1'b1, 9'(errs[5])};
    i_wr <= 1'b1;
    i_addr <= pbm_pkg::OFF_BIN_MAP;
    i_wdata <= nm;
    sq.push_back(exp_sel(map, 5));
    map = nm;
    @(posedge i_clk);
    i_sample.valid <= 1'b0;
    i_wr <= 1'b0;
    rd(pbm_pkg::OFF_BIN_MAP, map);
    repeat (3) @(posedge i_clk);
    smp(5, 1'b0);
    repeat (4) @(posedge i_clk);
    cmp32("pending samples", 32'h0, 32'(sq.size()));
    end_sim();
  end
endmodule
`default_nettype wire
